// ==== verilog/mcuie_consts.svh ====
`ifndef MCUIE_CONSTS_SVH
`define MCUIE_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets and file window address bit on the AHB-Lite slave
// ----------------------------------------------------------------------
`define MCUIE_OFS_INSTR      10'h000
`define MCUIE_OFS_ACC        10'h004
`define MCUIE_OFS_STATUS     10'h008
`define MCUIE_OFS_PC         10'h00C
`define MCUIE_OFS_PAGE       10'h010
`define MCUIE_OFS_STACK      10'h014
`define MCUIE_OFS_WDT        10'h018
`define MCUIE_OFS_WKT        10'h01C
`define MCUIE_FILE_WIN_BIT   9

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define MCUIE_ST_ZERO        0
`define MCUIE_ST_TIMEOUT     1
`define MCUIE_ST_PWRDOWN     2
`define MCUIE_ST_BANK0       3
`define MCUIE_ST_BUSY        4

// ----------------------------------------------------------------------
// Instruction fields and opcodes
// ----------------------------------------------------------------------
`define MCUIE_DEST_BIT       7
`define MCUIE_PAGE_HI        4
`define MCUIE_PAGE_LO        3
`define MCUIE_GRP_BYTE       2'h0
`define MCUIE_GRP_LIT        2'h1
`define MCUIE_GRP_JUMP       2'h2
`define MCUIE_GRP_BIT        2'h3
`define MCUIE_OP_MOVE_ACC    4'h0
`define MCUIE_OP_CLEAR       4'h1
`define MCUIE_OP_DEC         4'h3
`define MCUIE_OP_OR          4'h4
`define MCUIE_OP_AND         4'h5
`define MCUIE_OP_MOVE_FILE   4'h8
`define MCUIE_OP_COMPL       4'h9
`define MCUIE_OP_INC         4'hA
`define MCUIE_OP_DEC_SKIP    4'hB
`define MCUIE_OP_INC_SKIP    4'hF
`define MCUIE_OP_LOAD_LIT    4'h9
`define MCUIE_OP_OR_LIT      4'hA
`define MCUIE_BIT_CLEAR      2'h0
`define MCUIE_BIT_SET        2'h1
`define MCUIE_BIT_TEST_ZERO  2'h2
`define MCUIE_BIT_TEST_ONE   2'h3
`define MCUIE_CLEAR_ACC_WORD 14'h0140
`define MCUIE_WD_CLEAR_WORD  14'h1E04

// ----------------------------------------------------------------------
// Reset values, watchdog wrap compare value and bus response code
// ----------------------------------------------------------------------
`define MCUIE_RST_TIMEOUT    1'b1
`define MCUIE_RST_PWRDOWN    1'b1
`define MCUIE_WDT_MAX        16'hFFFF
`define MCUIE_RESP_OKAY      1'b0

`endif

// ==== verilog/mcuie_pkg.sv ====
package mcuie_pkg;

  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SECOND
  } mcuie_state_t;

  typedef logic [13:0] mcuie_word_t;
  typedef logic [7:0]  mcuie_byte_t;

endpackage : mcuie_pkg

// ==== verilog/mcuie_alu_if.sv ====
`timescale 1ns/1ps

// Decode request and result between the core and its decoder
interface mcuie_alu_if;
  mcuie_pkg::mcuie_word_t instr;
  mcuie_pkg::mcuie_byte_t acc;
  mcuie_pkg::mcuie_byte_t fval;
  mcuie_pkg::mcuie_byte_t result;
  logic                   to_acc;
  logic                   to_file;
  logic                   zero_upd;
  logic                   skip;
  logic                   is_call;
  logic                   is_branch;
  logic                   is_wd_clear;

  modport core (output instr, acc, fval,
                input  result, to_acc, to_file, zero_upd, skip,
                       is_call, is_branch, is_wd_clear);
  modport alu  (input  instr, acc, fval,
                output result, to_acc, to_file, zero_upd, skip,
                       is_call, is_branch, is_wd_clear);
endinterface : mcuie_alu_if

// ==== verilog/mcuie_alu.sv ====
`timescale 1ns/1ps
`include "mcuie_consts.svh"

module mcuie_alu (
  mcuie_alu_if.alu bus
);

  logic       dsel;
  logic [2:0] bsel;
  logic [7:0] bmask;

  assign dsel  = bus.instr[`MCUIE_DEST_BIT];
  assign bsel  = bus.instr[9:7];
  assign bmask = 8'h01 << bsel;

  // Pure decode: the core alone commits results
  always_comb begin
    bus.result      = 8'h00;
    bus.to_acc      = 1'b0;
    bus.to_file     = 1'b0;
    bus.zero_upd    = 1'b0;
    bus.skip        = 1'b0;
    bus.is_call     = 1'b0;
    bus.is_branch   = 1'b0;
    bus.is_wd_clear = 1'b0;
    unique case (bus.instr[13:12])
      `MCUIE_GRP_BYTE: begin
        bus.to_acc   = !dsel;
        bus.to_file  = dsel;
        bus.zero_upd = 1'b1;
        case (bus.instr[11:8])
          `MCUIE_OP_AND:       bus.result = bus.acc & bus.fval;
          `MCUIE_OP_COMPL:     bus.result = ~bus.fval;
          `MCUIE_OP_DEC:       bus.result = bus.fval - 8'h01;
          `MCUIE_OP_INC:       bus.result = bus.fval + 8'h01;
          `MCUIE_OP_OR:        bus.result = bus.acc | bus.fval;
          `MCUIE_OP_MOVE_FILE: bus.result = bus.fval;
          `MCUIE_OP_DEC_SKIP: begin
            bus.result   = bus.fval - 8'h01;
            bus.skip     = (bus.result == 8'h00);
            bus.zero_upd = 1'b0;
          end
          `MCUIE_OP_INC_SKIP: begin
            bus.result   = bus.fval + 8'h01;
            bus.skip     = (bus.result == 8'h00);
            bus.zero_upd = 1'b0;
          end
          `MCUIE_OP_CLEAR: begin
            // Clear-file when d is set, otherwise only the exact word
            bus.result   = 8'h00;
            bus.to_acc   = (bus.instr == `MCUIE_CLEAR_ACC_WORD);
            bus.zero_upd = dsel || bus.to_acc;
          end
          `MCUIE_OP_MOVE_ACC: begin
            bus.result   = bus.acc;
            bus.to_acc   = 1'b0;
            bus.zero_upd = 1'b0;
          end
          default: begin
            // Codes outside this block's set behave as a no-op
            bus.to_acc   = 1'b0;
            bus.to_file  = 1'b0;
            bus.zero_upd = 1'b0;
          end
        endcase
      end
      `MCUIE_GRP_LIT: begin
        if (bus.instr[11:8] == `MCUIE_OP_OR_LIT) begin
          bus.result   = bus.acc | bus.instr[7:0];
          bus.to_acc   = 1'b1;
          bus.zero_upd = 1'b1;
        end else if (bus.instr[11:8] == `MCUIE_OP_LOAD_LIT) begin
          bus.result = bus.instr[7:0];
          bus.to_acc = 1'b1;
        end
        bus.is_wd_clear = (bus.instr == `MCUIE_WD_CLEAR_WORD);
      end
      `MCUIE_GRP_JUMP: begin
        bus.is_call   = !bus.instr[11];
        bus.is_branch = bus.instr[11];
      end
      `MCUIE_GRP_BIT: begin
        unique case (bus.instr[11:10])
          `MCUIE_BIT_CLEAR: begin
            bus.result  = bus.fval & ~bmask;
            bus.to_file = 1'b1;
          end
          `MCUIE_BIT_SET: begin
            bus.result  = bus.fval | bmask;
            bus.to_file = 1'b1;
          end
          `MCUIE_BIT_TEST_ZERO: bus.skip = !bus.fval[bsel];
          `MCUIE_BIT_TEST_ONE:  bus.skip = bus.fval[bsel];
        endcase
      end
    endcase
  end

endmodule : mcuie_alu

// ==== verilog/mcuie_core.sv ====
`timescale 1ns/1ps
`include "mcuie_consts.svh"

// How it works
// - AND accumulator with file, to chosen destination
// - Bit clear in one cycle, flags kept
// - Bit set in one cycle, flags kept
// - Skip next when tested bit is zero
// - Skip next when tested bit is one
// - Call pushes return address, loads page and target
// - Branch loads page and target, stack untouched
// - Clear file writes zero, sets zero flag
// - Clear accumulator writes zero, sets zero flag
// - Watchdog clear with bank bit low zeroes both timers, updates flags
// - Complement file to chosen destination
// - Decrement and skip when result is zero
// - Increment file with wrap, zero flag updated
// - Increment and skip when result is zero
// - OR literal into accumulator, zero flag updated
// - OR accumulator with file to destination
// - Load literal into accumulator, flags kept
// - Copy accumulator into file register, flags kept
// - Seven-bit file address, three-bit bit index
// - Destination bit zero accumulator, one file
module mcuie_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // --------------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------------
  mcuie_pkg::mcuie_state_t state_q;
  mcuie_pkg::mcuie_word_t  instr_q;
  mcuie_pkg::mcuie_byte_t  acc_q;
  mcuie_pkg::mcuie_byte_t  file_mem [0:127];
  logic [12:0]             stack_mem [0:7];
  logic [12:0]             pc_q;
  logic [7:0]              page_q;
  logic [2:0]              sp_q;
  logic                    zero_q;
  logic                    timeout_q;
  logic                    powerdown_q;
  logic                    bank0_q;
  logic [15:0]             wdt_q;
  logic [15:0]             wkt_q;
  logic [9:0]              addr_q;
  logic                    map_q;
  logic                    wr_q;
  logic                    pend_q;
  logic                    hreadyout_q;
  logic                    hresp_q;
  logic [31:0]             hrdata_q;
  logic [31:0]             rd_d;
  logic [6:0]              f_addr;
  logic [2:0]              b_sel;
  logic                    exec;
  logic                    accept;
  logic                    done;
  logic                    bus_wr;
  logic                    file_win;
  logic                    wd_clear;
  logic [12:0]             stack_top;

  mcuie_alu_if alu_bus ();

  mcuie_alu u_alu (
    .bus (alu_bus)
  );

  // --------------------------------------------------------------------
  // Decoder hookup
  // --------------------------------------------------------------------
  assign f_addr          = instr_q[6:0];
  assign b_sel           = instr_q[9:7];
  assign alu_bus.instr   = instr_q;
  assign alu_bus.acc     = acc_q;
  assign alu_bus.fval    = file_mem[f_addr];
  assign exec            = (state_q == mcuie_pkg::ST_EXEC);
  assign stack_top       = stack_mem[sp_q - 3'h1];

  // Watchdog clear with bank bit set is illegal; it is dropped as a no-op
  assign wd_clear = exec && alu_bus.is_wd_clear && !bank0_q;

  // --------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------
  assign accept   = hsel && htrans[1] && hready;
  // Data phase completes only when the core is idle, so software never
  // touches state that an instruction is still updating
  assign done     = pend_q && (state_q == mcuie_pkg::ST_IDLE);
  assign bus_wr   = done && wr_q && map_q;
  assign file_win = addr_q[`MCUIE_FILE_WIN_BIT];

  // Address phase capture and wait-state generation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q      <= 1'b0;
      addr_q      <= 10'h000;
      map_q       <= 1'b0;
      wr_q        <= 1'b0;
      hreadyout_q <= 1'b1;
    end else if (accept) begin
      pend_q      <= 1'b1;
      addr_q      <= haddr[9:0];
      // Anything above the file window, or not a word, is unmapped
      map_q       <= (haddr[31:10] == 22'h000000) && (hsize == 3'h2);
      wr_q        <= hwrite;
      hreadyout_q <= 1'b0;
    end else if (done) begin
      pend_q      <= 1'b0;
      hreadyout_q <= 1'b1;
    end
  end

  // Read mux; unmapped and reserved bits read as zero
  always_comb begin
    rd_d = 32'h00000000;
    if (map_q && file_win) begin
      rd_d[7:0] = file_mem[addr_q[8:2]];
    end else if (map_q) begin
      case (addr_q)
        `MCUIE_OFS_INSTR:  rd_d[13:0] = instr_q;
        `MCUIE_OFS_ACC:    rd_d[7:0]  = acc_q;
        `MCUIE_OFS_STATUS: begin
          rd_d[`MCUIE_ST_ZERO]    = zero_q;
          rd_d[`MCUIE_ST_TIMEOUT] = timeout_q;
          rd_d[`MCUIE_ST_PWRDOWN] = powerdown_q;
          rd_d[`MCUIE_ST_BANK0]   = bank0_q;
          rd_d[`MCUIE_ST_BUSY]    = (state_q != mcuie_pkg::ST_IDLE);
        end
        `MCUIE_OFS_PC:     rd_d[12:0] = pc_q;
        `MCUIE_OFS_PAGE:   rd_d[7:0]  = page_q;
        `MCUIE_OFS_STACK:  rd_d[12:0] = stack_top;
        `MCUIE_OFS_WDT:    rd_d[15:0] = wdt_q;
        `MCUIE_OFS_WKT:    rd_d[15:0] = wkt_q;
        default:           rd_d       = 32'h00000000;
      endcase
    end
  end

  // Read data and response are registered; writes return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hresp_q  <= `MCUIE_RESP_OKAY;
    end else begin
      hresp_q <= `MCUIE_RESP_OKAY;
      if (done) begin
        hrdata_q <= wr_q ? 32'h00000000 : rd_d;
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  // --------------------------------------------------------------------
  // Execution sequencer
  // --------------------------------------------------------------------
  // A write to the instruction register launches one instruction; jumps
  // and taken skips spend a second, empty cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= mcuie_pkg::ST_IDLE;
      instr_q <= 14'h0000;
    end else begin
      unique case (state_q)
        mcuie_pkg::ST_IDLE: begin
          if (bus_wr && !file_win && addr_q == `MCUIE_OFS_INSTR) begin
            instr_q <= hwdata[13:0];
            state_q <= mcuie_pkg::ST_EXEC;
          end
        end
        mcuie_pkg::ST_EXEC: begin
          if (alu_bus.skip || alu_bus.is_call || alu_bus.is_branch) begin
            state_q <= mcuie_pkg::ST_SECOND;
          end else begin
            state_q <= mcuie_pkg::ST_IDLE;
          end
        end
        mcuie_pkg::ST_SECOND: state_q <= mcuie_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Architectural state
  // --------------------------------------------------------------------
  // Accumulator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 8'h00;
    end else if (exec && alu_bus.to_acc) begin
      acc_q <= alu_bus.result;
    end else if (bus_wr && !file_win && addr_q == `MCUIE_OFS_ACC) begin
      acc_q <= hwdata[7:0];
    end
  end

  // Zero flag follows the result only for instructions that update it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_q <= 1'b0;
    end else if (exec && alu_bus.zero_upd) begin
      zero_q <= (alu_bus.result == 8'h00);
    end else if (bus_wr && !file_win && addr_q == `MCUIE_OFS_STATUS) begin
      zero_q <= hwdata[`MCUIE_ST_ZERO];
    end
  end

  // Bank select bit, software owned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank0_q <= 1'b0;
    end else if (bus_wr && !file_win && addr_q == `MCUIE_OFS_STATUS) begin
      bank0_q <= hwdata[`MCUIE_ST_BANK0];
    end
  end

  // File registers; no reset, contents are undefined at power-up
  always_ff @(posedge hclk) begin
    if (exec && alu_bus.to_file) begin
      file_mem[f_addr] <= alu_bus.result;
    end else if (bus_wr && file_win) begin
      file_mem[addr_q[8:2]] <= hwdata[7:0];
    end
  end

  // Page latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= 8'h00;
    end else if (bus_wr && !file_win && addr_q == `MCUIE_OFS_PAGE) begin
      page_q <= hwdata[7:0];
    end
  end

  // Program counter: taken skips step over the next word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= 13'h0000;
    end else if (exec) begin
      if (alu_bus.is_call || alu_bus.is_branch) begin
        pc_q <= {page_q[`MCUIE_PAGE_HI:`MCUIE_PAGE_LO],
                 instr_q[10:0]};
      end else if (alu_bus.skip) begin
        pc_q <= pc_q + 13'h0002;
      end else begin
        pc_q <= pc_q + 13'h0001;
      end
    end else if (bus_wr && !file_win && addr_q == `MCUIE_OFS_PC) begin
      pc_q <= hwdata[12:0];
    end
  end

  // Return stack: circular, the oldest entry is overwritten on overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= 3'h0;
    end else if (exec && alu_bus.is_call) begin
      sp_q <= sp_q + 3'h1;
    end
  end

  always_ff @(posedge hclk) begin
    if (exec && alu_bus.is_call) begin
      stack_mem[sp_q] <= pc_q + 13'h0001;
    end
  end

  // Watchdog and wake-up counters run freely until cleared
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_q <= 16'h0000;
      wkt_q <= 16'h0000;
    end else if (wd_clear) begin
      wdt_q <= 16'h0000;
      wkt_q <= 16'h0000;
    end else begin
      wdt_q <= wdt_q + 16'h0001;
      wkt_q <= wkt_q + 16'h0001;
    end
  end

  // Time-out flag drops when the watchdog wraps; a clear re-arms both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_q   <= `MCUIE_RST_TIMEOUT;
      powerdown_q <= `MCUIE_RST_PWRDOWN;
    end else if (wd_clear) begin
      timeout_q   <= 1'b1;
      powerdown_q <= 1'b1;
    end else if (wdt_q == `MCUIE_WDT_MAX) begin
      timeout_q   <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  and_to_acc_a: assert property (
    exec && instr_q[13:8] == 6'h05 && !instr_q[7]
    |=> acc_q == ($past(acc_q) & $past(alu_bus.fval))
        && zero_q == (acc_q == 8'h00))
    else $error("and with file gave wrong accumulator");

  bit_clear_a: assert property (
    exec && instr_q[13:10] == 4'hC
    |=> file_mem[$past(f_addr)][$past(b_sel)] == 1'b0 && $stable(zero_q))
    else $error("bit clear left bit set or moved flag");

  bit_set_a: assert property (
    exec && instr_q[13:10] == 4'hD
    |=> file_mem[$past(f_addr)][$past(b_sel)] == 1'b1 && $stable(zero_q))
    else $error("bit set left bit clear or moved flag");

  skip_two_cycle_a: assert property (
    exec && alu_bus.skip
    |=> state_q == mcuie_pkg::ST_SECOND && pc_q == $past(pc_q) + 13'h0002
    ##1 state_q == mcuie_pkg::ST_IDLE)
    else $error("taken skip did not take two cycles");

  test_one_skip_a: assert property (
    exec && instr_q[13:10] == 4'hF && !alu_bus.fval[b_sel]
    |=> state_q == mcuie_pkg::ST_IDLE && pc_q == $past(pc_q) + 13'h0001)
    else $error("untaken skip was not one cycle");

  call_push_a: assert property (
    exec && alu_bus.is_call
    |=> stack_top == $past(pc_q) + 13'h0001
        && pc_q[10:0] == $past(instr_q[10:0])
        && pc_q[12:11] == $past(page_q[`MCUIE_PAGE_HI:`MCUIE_PAGE_LO]))
    else $error("call did not push or load target");

  branch_load_a: assert property (
    exec && alu_bus.is_branch
    |=> pc_q[10:0] == $past(instr_q[10:0]) && $stable(sp_q)
    ##1 state_q == mcuie_pkg::ST_IDLE)
    else $error("branch target or stack wrong");

  clear_sets_zero_a: assert property (
    exec && instr_q[13:7] == 7'h03
    |=> file_mem[$past(f_addr)] == 8'h00 && zero_q)
    else $error("clear file did not zero and flag");

  wd_clear_a: assert property (
    wd_clear |=> wdt_q == 16'h0000 && wkt_q == 16'h0000
                 && timeout_q && powerdown_q)
    else $error("watchdog clear did not reset timers");

  load_lit_flags_a: assert property (
    exec && instr_q[13:8] == 6'h19
    |=> acc_q == $past(instr_q[7:0]) && $stable(zero_q))
    else $error("load literal wrong or flag moved");

  zero_track_a: assert property (
    exec && alu_bus.zero_upd
    |=> zero_q == ($past(alu_bus.result) == 8'h00))
    else $error("zero flag disagrees with result");

  // A request taken while a jump is still executing waits up to three
  // cycles for the core to go idle before the data phase completes
  bus_wait_a: assert property (
    accept |=> !hreadyout ##[1:3] hreadyout)
    else $error("slave answer timing broken");

endmodule : mcuie_core

// ==== tb/mcuie_prog_rom.sv ====
`timescale 1ns/1ps
// Program store fetched by the bench at the core's PC
module mcuie_prog_rom (
  input  wire logic [12:0]       pc,
  output mcuie_pkg::mcuie_word_t word
);
  // Skip tests first; the watchdog clear runs with the bank bit low
  always_comb begin
    case (pc)
      13'h0000: word = 14'h3A00; // Bit 4 of file 0 set: no skip
      13'h0001: word = 14'h3E00; // Bit 4 set: skip the next word
      13'h0002: word = 14'h0140; // Skipped, must never run
      13'h0003: word = 14'h0B80; // Decrement file 0, no skip
      default:  word = 14'h1E04;
    endcase
  end
endmodule : mcuie_prog_rom

// ==== tb/tb_mcuie_core.sv ====
`timescale 1ns/1ps
`include "mcuie_consts.svh"
module tb_mcuie_core;
  logic                   hclk;
  logic                   hresetn;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [12:0]            pc;
  mcuie_pkg::mcuie_word_t word;
  logic [31:0]            rv;
  int                     n_fail;
  int                     cmp_count;
  int                     cyc = 0;

  mcuie_core mcuie_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  mcuie_prog_rom mcuie_prog_rom_inst (.pc(pc), .word(word));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Hang guard, far above the roughly 730 cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  // ----------
  // Bus tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Single word transfer; each phase held until hready is seen high
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, `MCUIE_RESP_OKAY}); // Response always OKAY
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, rv);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, rv);
    chk(rv, e);
  endtask : rdc
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    rdc(`MCUIE_OFS_ACC, 32'h0);
    rdc(`MCUIE_OFS_STATUS, 32'h6);
    rdc(`MCUIE_OFS_PC, 32'h0);
    rdc(32'h100, 32'h0); // Reserved offset reads zero
  endtask : t_reset
  // Byte ops on file 7F, both destinations; zero flag preset clear
  task automatic t_byte();
    logic [3:0] op [6] = '{4'h5, 4'h4, 4'h9, 4'h3, 4'hA, 4'h8};
    logic [7:0] ex [6] = '{8'h3C, 8'hFF, 8'h00, 8'hFE, 8'h00, 8'hFF};
    for (int i = 0; i < 6; i++) begin
      for (int d = 0; d < 2; d++) begin
        wr(`MCUIE_OFS_ACC, 32'h3C);
        wr(32'h3FC, 32'hFF);
        wr(`MCUIE_OFS_STATUS, 32'h0);
        wr(`MCUIE_OFS_INSTR, {18'h0, 2'b00, op[i], d[0], 7'h7F});
        rdc(`MCUIE_OFS_ACC, d ? 32'h3C : {24'h0, ex[i]});
        rdc(32'h3FC, d ? {24'h0, ex[i]} : 32'hFF);
        rdc(`MCUIE_OFS_STATUS, {31'h3, ex[i] == 8'h00});
      end
    end
  endtask : t_byte
  // Word, then expected acc, file 7F and status; zero flag preset set
  task automatic t_misc();
    logic [39:0] t [10] = '{40'h01FF3C0007, 40'h0140004A07, 40'h00FF3C3C07,
      40'h195A5A4A07, 40'h1A353D4A06, 40'h337F3C0A07, 40'h37FF3CCA07,
      40'h0BFF3C4907, 40'h0FFF3C4B07, 40'h3C7F3C4A07};
    for (int i = 0; i < 10; i++) begin
      wr(`MCUIE_OFS_ACC, 32'h3C);
      wr(32'h3FC, 32'h4A);
      wr(`MCUIE_OFS_STATUS, 32'h1);
      wr(`MCUIE_OFS_INSTR, {18'h0, t[i][37:24]});
      rdc(`MCUIE_OFS_ACC, {24'h0, t[i][23:16]});
      rdc(32'h3FC, {24'h0, t[i][15:8]});
      rdc(`MCUIE_OFS_STATUS, {24'h0, t[i][7:0]});
    end
  endtask : t_misc
  // Call then branch with page bits 11 in the latch
  task automatic t_jump();
    wr(`MCUIE_OFS_PAGE, 32'h18);
    wr(`MCUIE_OFS_PC, 32'h5);
    wr(`MCUIE_OFS_INSTR, 32'h2456);
    rdc(`MCUIE_OFS_PC, 32'h1C56);
    rdc(`MCUIE_OFS_STACK, 32'h6);
    wr(`MCUIE_OFS_INSTR, 32'h2923);
    rdc(`MCUIE_OFS_PC, 32'h1923);
    rdc(`MCUIE_OFS_STACK, 32'h6);
  endtask : t_jump
  // Runs the stored program from PC 0, one fetch per instruction
  task automatic t_skip();
    logic [31:0] pcs [4] = '{32'h0, 32'h1, 32'h3, 32'h4};
    wr(32'h200, 32'h10);
    wr(`MCUIE_OFS_PC, 32'h0);
    wr(`MCUIE_OFS_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(`MCUIE_OFS_PC, 1'b0, 32'h0, rv);
      chk(rv, pcs[i]);
      pc = rv[12:0];
      @(posedge hclk); // Let the program store settle on the new PC
      wr(`MCUIE_OFS_INSTR, {18'h0, word});
    end
    xfer(`MCUIE_OFS_WDT, 1'b0, 32'h0, rv);
    chk(rv < 32'h10, 1'b1);
    rdc(`MCUIE_OFS_STATUS, 32'h6);
    rdc(32'h200, 32'h0F);
    rdc(`MCUIE_OFS_PC, 32'h5);
  endtask : t_skip

  // Reset for three cycles, then every scenario in turn
  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h0;
    pc        = 13'h0;
    n_fail    = 0;
    cmp_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_byte();
    t_misc();
    t_jump();
    t_skip();
    give_verdict();
  end
endmodule : tb_mcuie_core
